// >>> verilog/rir_top.sv
// Functional notes
// RL1: Interrupt wake with global enable set loads program counter with vector 0004h.
// RL2: Brown-out reset clears power status bit 0; other resets leave it unchanged.
// RL3: Address-mask register shares 93h; selected only when serial mode field is 1001.
// RL4: Interrupt wake sets source flag bits in interrupt control or peripheral flags.
// RL5: Brown-out with critically low supply performs full power-on initialization instead.
// RL6: Unimplemented bits always read as zero under every reset and wake condition.
// RL7: Power-on and warm resets load tabulated values; wake keeps contents except fixed.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "rir_regs.svh"
module rir_top #(
  parameter int ADDR_W = 9
) (
  input  wire logic                CLK,
  input  wire logic                RESET,
  input  wire logic [ADDR_W-1:0]   ADDR,
  input  wire logic [7:0]          WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic [7:0]               RDATA,
  input  wire logic [3:0]          SYNC_SERIAL_MODE_SELECT,
  input  wire logic                EXTERNAL_RESET_PIN,
  input  wire logic                WATCHDOG_TIMER_RESET,
  input  wire logic                BROWNOUT_RESET,
  input  wire logic                SUPPLY_CRITICAL,
  input  wire logic                SLEEP_REQ,
  input  wire logic                WAKE_IRQ,
  input  wire logic                WATCHDOG_TIMER_WAKE,
  input  wire logic                GLOBAL_IRQ_ENABLE,
  input  wire logic [7:0]          WAKE_SRC_INTERRUPT_CONTROL_REG,
  input  wire logic [7:0]          WAKE_SRC_PERIPHERAL_IRQ_FLAGS_1,
  output logic [7:0]               INTERRUPT_CONTROL_REG_SET,
  output logic [7:0]               PERIPHERAL_IRQ_FLAGS_1_SET,
  output logic                     PC_LOAD,
  output logic [12:0]              PC_VECTOR,
  output logic                     ASLEEP,
  output logic                     BROWNOUT_FLAG,
  output logic                     IRQ
);

  // ---------------------------------------------------------------
  // Parameter checks and local types
  // ---------------------------------------------------------------
  if (ADDR_W != 9) $error("rir_top: ADDR_W must be 9 to reach the upper bank");

  localparam int NREG = `RIR_NREG;

  typedef struct packed {
    logic              hit;
    rir_pkg::rir_idx_t idx;
  } rir_decode_t;

  // ---------------------------------------------------------------
  // Reset and wake table
  // ---------------------------------------------------------------
  function automatic rir_pkg::rir_entry_t entry_of(input int unsigned i);
    rir_pkg::rir_entry_t e;
    e = '0;
    case (i)
      0       : e = `RIR_CC2_VAL_HI;
      1       : e = `RIR_CC2_CTRL;
      2       : e = `RIR_ADC_RES_HI;
      3       : e = `RIR_ADC_CTRL0;
      4       : e = `RIR_TMR0_OPT;
      5       : e = `RIR_PA_DIR;
      6       : e = `RIR_PB_DIR;
      7       : e = `RIR_PC_DIR;
      8       : e = `RIR_PD_DIR;
      9       : e = `RIR_PE_DIR;
      10      : e = `RIR_PIRQ_EN1;
      11      : e = `RIR_PIRQ_EN2;
      12      : e = `RIR_PWR_RST;
      13      : e = `RIR_OSC_CTRL;
      14      : e = `RIR_OSC_TUNE;
      15      : e = `RIR_SS_CTRL2;
      16      : e = `RIR_T2_PERIOD;
      17      : e = `RIR_SS_ADDR;
      18      : e = `RIR_SS_MASK;
      19      : e = `RIR_SS_STAT;
      20      : e = `RIR_PB_PULLUP;
      21      : e = `RIR_PB_CHG_EN;
      22      : e = `RIR_VREF_CTRL;
      23      : e = `RIR_UART_TX;
      24      : e = `RIR_BAUD_LO;
      25      : e = `RIR_BAUD_HI;
      26      : e = `RIR_PWM_RESTART;
      27      : e = `RIR_PWM_SHUTDN;
      28      : e = `RIR_PWM_STEER;
      29      : e = `RIR_ADC_RES_LO;
      30      : e = `RIR_ADC_CTRL1;
      31      : e = `RIR_WDOG_CTRL;
      32      : e = `RIR_CMP1_CTRL;
      33      : e = `RIR_CMP2_CTRL;
      default : e = '0;
    endcase
    return e;
  endfunction : entry_of

  // ---------------------------------------------------------------
  // Address decode, shared by read and write paths
  // ---------------------------------------------------------------
  function automatic rir_decode_t decode(input logic [ADDR_W-1:0] a, input logic [3:0] mode);
    rir_decode_t         d;
    rir_pkg::rir_entry_t e;
    d = '0;
    // RL3: shared offset steering
    if (a == `RIR_SS_SHARED_OFS)
    begin
      d.hit = 1'b1;
      d.idx = (mode == `RIR_SS_MASK_MODE) ? `RIR_IDX_SS_MASK : `RIR_IDX_SS_ADDR;
    end
    else
    begin
      for (int unsigned i = 0; i < NREG; i++)
      begin
        e = entry_of(i);
        if (e.ofs == a)
        begin
          d.hit = 1'b1;
          d.idx = 6'(i);
        end
      end
    end
    return d;
  endfunction : decode

  // Warm value: keep-mask bits hold, the rest take the table value
  function automatic rir_pkg::rir_byte_t warm_of(input rir_pkg::rir_entry_t e, input rir_pkg::rir_byte_t cur);
    return (cur & e.keep) | (e.warm & ~e.keep);
  endfunction : warm_of

  // Single-field helpers; some front ends refuse a select on a call
  function automatic rir_pkg::rir_byte_t impl_of(input int unsigned i);
    rir_pkg::rir_entry_t e;
    e = entry_of(i);
    return e.impl;
  endfunction : impl_of

  function automatic rir_pkg::rir_byte_t por_of(input int unsigned i);
    rir_pkg::rir_entry_t e;
    e = entry_of(i);
    return e.por & e.impl;
  endfunction : por_of

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  rir_pkg::rir_byte_t regs_q [NREG];
  rir_pkg::rir_byte_t regs_d [NREG];
  rir_decode_t        wr_dec;
  rir_decode_t        rd_dec;
  logic               wr_hit;
  logic               wr_stat;
  logic               wr_mask;
  logic               wake_any;
  logic [7:0]         evt_stat_q;
  logic [7:0]         evt_mask_q;
  rir_pkg::rir_byte_t rd_value;

  rir_ctl_if ctl ();

  // ---------------------------------------------------------------
  // Power state and reset-source qualification
  // ---------------------------------------------------------------
  rir_power u_power (
    .clk         (CLK),
    .rst         (RESET),
    .sleep_req   (SLEEP_REQ),
    .ext_rst     (EXTERNAL_RESET_PIN),
    .wdt_rst     (WATCHDOG_TIMER_RESET),
    .bor_rst     (BROWNOUT_RESET),
    .supply_low  (SUPPLY_CRITICAL),
    .wake_irq_in (WAKE_IRQ),
    .wake_wdt_in (WATCHDOG_TIMER_WAKE),
    .ctl         (ctl.src)
  );

  // ---------------------------------------------------------------
  // Event status, mask and interrupt line
  // ---------------------------------------------------------------
  rir_events #(
    .W (`RIR_EVT_W)
  ) u_events (
    .clk     (CLK),
    .rst     (RESET),
    .evt     (ctl.evt),
    .wr_stat (wr_stat),
    .wr_mask (wr_mask),
    .wdata   (WDATA),
    .stat_q  (evt_stat_q),
    .mask_q  (evt_mask_q),
    .irq_q   (IRQ)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign wr_dec   = decode(ADDR, SYNC_SERIAL_MODE_SELECT);
  assign rd_dec   = wr_dec;
  assign wr_hit   = WR & wr_dec.hit;
  assign wr_stat  = WR & (ADDR == `RIR_ADDR_EVT_STAT);
  assign wr_mask  = WR & (ADDR == `RIR_ADDR_EVT_MASK);
  assign wake_any = ctl.wake_irq | ctl.wake_wdt;

  // ---------------------------------------------------------------
  // Register next state
  // ---------------------------------------------------------------
  // Priority: full init, warm reset, fixed wake values, software write.
  // A write landing with a reset is dropped, the reset owns the cycle.
  always_comb
  begin
    rir_pkg::rir_entry_t e;
    rir_pkg::rir_byte_t  d;
    e = '0;
    d = '0;
    for (int unsigned i = 0; i < NREG; i++)
    begin
      e = entry_of(i);
      d = regs_q[i];
      // RL6: unimplemented bits dropped
      if (wr_hit && (wr_dec.idx == 6'(i)))
        d = WDATA & e.impl;
      // RL7: fixed on wake
      if (wake_any && ((6'(i) == `RIR_IDX_T2_PERIOD) || (6'(i) == `RIR_IDX_SS_MASK)))
        d = `RIR_WAKE_FIXED & e.impl;
      // RL7: warm reset values
      if (ctl.warm_init)
        d = warm_of(e, regs_q[i]) & e.impl;
      // RL2: brown-out clears bit 0
      if (ctl.bor_hit && (6'(i) == `RIR_IDX_PWR_RST))
        d[`RIR_BOR_BIT] = 1'b0;
      // RL5: critical supply forces full init
      if (ctl.full_init)
        d = e.por & e.impl;
      regs_d[i] = d;
    end
  end

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      // RL7: power-on values
      for (int unsigned i = 0; i < NREG; i++)
        regs_q[i] <= por_of(i);
    end
    else
    begin
      for (int unsigned i = 0; i < NREG; i++)
        regs_q[i] <= regs_d[i];
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_value = 8'h00;
    if (ADDR == `RIR_ADDR_EVT_STAT)
      rd_value = evt_stat_q;
    else if (ADDR == `RIR_ADDR_EVT_MASK)
      rd_value = evt_mask_q;
    else if (rd_dec.hit)
      // RL6: reads masked to implemented bits
      rd_value = regs_q[rd_dec.idx] & impl_of(32'(rd_dec.idx));
  end

  // Data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      RDATA <= 8'h00;
    else
      RDATA <= RD ? rd_value : 8'h00;
  end

  // ---------------------------------------------------------------
  // Wake actions toward the core
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      PC_LOAD   <= 1'b0;
      PC_VECTOR <= 13'h0000;
    end
    else
    begin
      // RL1: vector load on enabled wake
      PC_LOAD <= ctl.wake_irq & GLOBAL_IRQ_ENABLE;
      if (ctl.wake_irq && GLOBAL_IRQ_ENABLE)
        PC_VECTOR <= `RIR_IRQ_VECTOR;
    end
  end

  // Flag sets are one-cycle pulses; the flag registers live in the core
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      INTERRUPT_CONTROL_REG_SET  <= 8'h00;
      PERIPHERAL_IRQ_FLAGS_1_SET <= 8'h00;
    end
    else
    begin
      // RL4: mark the wake source
      INTERRUPT_CONTROL_REG_SET  <= ctl.wake_irq ? WAKE_SRC_INTERRUPT_CONTROL_REG : 8'h00;
      PERIPHERAL_IRQ_FLAGS_1_SET <= ctl.wake_irq ? WAKE_SRC_PERIPHERAL_IRQ_FLAGS_1 : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  // Taken from next state so the pin agrees with a read of the register
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      BROWNOUT_FLAG <= 1'b0;
    else
      BROWNOUT_FLAG <= regs_d[`RIR_IDX_PWR_RST][`RIR_BOR_BIT];
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      ASLEEP <= 1'b0;
    else
      ASLEEP <= ctl.asleep;
  end

endmodule : rir_top

// >>> verilog/rir_regs.svh
`ifndef RIR_REGS_SVH
`define RIR_REGS_SVH
// Entry layout: {offset[8:0], implemented bits, power-on, warm value, warm keep mask}
`define RIR_CC2_VAL_HI     {9'h01C, 8'hFF, 8'h00, 8'h00, 8'hFF}
`define RIR_CC2_CTRL       {9'h01D, 8'h3F, 8'h00, 8'h00, 8'h00}
`define RIR_ADC_RES_HI     {9'h01E, 8'hFF, 8'h00, 8'h00, 8'hFF}
`define RIR_ADC_CTRL0      {9'h01F, 8'hDF, 8'h00, 8'h00, 8'h00}
`define RIR_TMR0_OPT       {9'h081, 8'hFF, 8'hFF, 8'hFF, 8'h00}
`define RIR_PA_DIR         {9'h085, 8'hFF, 8'hFF, 8'hFF, 8'h00}
`define RIR_PB_DIR         {9'h086, 8'hFF, 8'hFF, 8'hFF, 8'h00}
`define RIR_PC_DIR         {9'h087, 8'hFF, 8'hFF, 8'hFF, 8'h00}
`define RIR_PD_DIR         {9'h088, 8'hFF, 8'hFF, 8'hFF, 8'h00}
`define RIR_PE_DIR         {9'h089, 8'h0F, 8'h0F, 8'h0F, 8'h00}
`define RIR_PIRQ_EN1       {9'h08C, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_PIRQ_EN2       {9'h08D, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_PWR_RST        {9'h08E, 8'h33, 8'h10, 8'h00, 8'h13}
`define RIR_OSC_CTRL       {9'h08F, 8'h7F, 8'h60, 8'h60, 8'h00}
`define RIR_OSC_TUNE       {9'h090, 8'h1F, 8'h00, 8'h00, 8'h1F}
`define RIR_SS_CTRL2       {9'h091, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_T2_PERIOD      {9'h092, 8'hFF, 8'hFF, 8'hFF, 8'h00}
`define RIR_SS_ADDR        {9'h093, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_SS_MASK        {9'h093, 8'hFF, 8'hFF, 8'hFF, 8'h00}
`define RIR_SS_STAT        {9'h094, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_PB_PULLUP      {9'h095, 8'hFF, 8'hFF, 8'hFF, 8'h00}
`define RIR_PB_CHG_EN      {9'h096, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_VREF_CTRL      {9'h097, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_UART_TX        {9'h098, 8'hF7, 8'h02, 8'h02, 8'h00}
`define RIR_BAUD_LO        {9'h099, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_BAUD_HI        {9'h09A, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_PWM_RESTART    {9'h09B, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_PWM_SHUTDN     {9'h09C, 8'hFF, 8'h00, 8'h00, 8'h00}
`define RIR_PWM_STEER      {9'h09D, 8'h1F, 8'h01, 8'h01, 8'h00}
`define RIR_ADC_RES_LO     {9'h09E, 8'hFF, 8'h00, 8'h00, 8'hFF}
`define RIR_ADC_CTRL1      {9'h09F, 8'hB0, 8'h00, 8'h00, 8'h00}
`define RIR_WDOG_CTRL      {9'h105, 8'h1F, 8'h08, 8'h08, 8'h00}
`define RIR_CMP1_CTRL      {9'h107, 8'hFB, 8'h00, 8'h00, 8'h00}
`define RIR_CMP2_CTRL      {9'h108, 8'hFB, 8'h00, 8'h00, 8'h00}
`define RIR_NREG           34
`define RIR_IDX_PWR_RST    6'h0C
`define RIR_IDX_T2_PERIOD  6'h10
`define RIR_IDX_SS_ADDR    6'h11
`define RIR_IDX_SS_MASK    6'h12
`define RIR_SS_SHARED_OFS  9'h093
`define RIR_SS_MASK_MODE   4'h9
`define RIR_WAKE_FIXED     8'hFF
`define RIR_BOR_BIT        0
`define RIR_IRQ_VECTOR     13'h0004
`define RIR_ADDR_EVT_STAT  9'h1F0
`define RIR_ADDR_EVT_MASK  9'h1F1
`define RIR_EVT_STAT_RST   8'h01
`define RIR_EVT_MASK_RST   8'h00
`define RIR_EVT_W          7
`endif

// >>> verilog/rir_pkg.sv
package rir_pkg;
  typedef logic [7:0] rir_byte_t;
  typedef logic [5:0] rir_idx_t;
  typedef struct packed {
    logic [8:0] ofs;
    rir_byte_t  impl;
    rir_byte_t  por;
    rir_byte_t  warm;
    rir_byte_t  keep;
  } rir_entry_t;
  typedef enum logic {RIR_RUN, RIR_SLEEP} rir_pwr_t;
endpackage : rir_pkg

// >>> verilog/rir_ctl_if.sv
`timescale 1ns/1ps
interface rir_ctl_if;
  logic       full_init;
  logic       warm_init;
  logic       bor_hit;
  logic       wake_irq;
  logic       wake_wdt;
  logic       asleep;
  logic [6:0] evt;
  modport src (output full_init, warm_init, bor_hit, wake_irq, wake_wdt, asleep, evt);
  modport snk (input  full_init, warm_init, bor_hit, wake_irq, wake_wdt, asleep, evt);
endinterface : rir_ctl_if

// >>> verilog/rir_power.sv
`timescale 1ns/1ps
module rir_power (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sleep_req,
  input  wire logic ext_rst,
  input  wire logic wdt_rst,
  input  wire logic bor_rst,
  input  wire logic supply_low,
  input  wire logic wake_irq_in,
  input  wire logic wake_wdt_in,
  rir_ctl_if.src    ctl
);
  rir_pkg::rir_pwr_t state_q;
  logic              any_rst;

  // Any reset source beats a wake request in the same cycle
  assign any_rst       = ext_rst | wdt_rst | bor_rst;
  assign ctl.full_init = bor_rst & supply_low;
  assign ctl.bor_hit   = bor_rst & ~supply_low;
  assign ctl.warm_init = (ext_rst | wdt_rst | ctl.bor_hit) & ~ctl.full_init;
  assign ctl.asleep    = (state_q == rir_pkg::RIR_SLEEP);
  assign ctl.wake_irq  = ctl.asleep & wake_irq_in & ~any_rst;
  assign ctl.wake_wdt  = ctl.asleep & wake_wdt_in & ~any_rst;
  assign ctl.evt       = {ctl.wake_wdt, ctl.wake_irq, ctl.bor_hit, wdt_rst, ext_rst, ctl.full_init, 1'b0};

  always_ff @(posedge clk or posedge rst)
    if (rst)
      state_q <= rir_pkg::RIR_RUN;
    else
      case (state_q)
        rir_pkg::RIR_RUN   : if (sleep_req && !any_rst) state_q <= rir_pkg::RIR_SLEEP;
        rir_pkg::RIR_SLEEP : if (any_rst || wake_irq_in || wake_wdt_in) state_q <= rir_pkg::RIR_RUN;
        default            : state_q <= rir_pkg::RIR_RUN;
      endcase
endmodule : rir_power

// >>> verilog/rir_events.sv
`timescale 1ns/1ps
`include "rir_regs.svh"
module rir_events #(
  parameter int W = 7
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [W-1:0]     evt,
  input  wire logic             wr_stat,
  input  wire logic             wr_mask,
  input  wire rir_pkg::rir_byte_t wdata,
  output logic [7:0]            stat_q,
  output logic [7:0]            mask_q,
  output logic                  irq_q
);
  logic [7:0] stat_d;
  logic [7:0] mask_d;

  if (W < 1 || W > 8) $error("rir_events: W must be 1..8");

  // Set wins over a write-one-to-clear in the same cycle
  assign stat_d = (stat_q & ~(wr_stat ? wdata : 8'h00)) | 8'(evt);
  assign mask_d = wr_mask ? wdata : mask_q;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      stat_q <= `RIR_EVT_STAT_RST;
      mask_q <= `RIR_EVT_MASK_RST;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= |(stat_d & mask_d);
    end
endmodule : rir_events

// >>> verification/rir_top_sva.sv
`timescale 1ns/1ps
module rir_top_sva #(
  parameter int ADDR_W = 9
) (
  input wire logic              CLK,
  input wire logic              RESET,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic              RD,
  input wire logic [7:0]        RDATA,
  input wire logic              BROWNOUT_RESET,
  input wire logic              SUPPLY_CRITICAL,
  input wire logic              WAKE_IRQ,
  input wire logic              GLOBAL_IRQ_ENABLE,
  input wire logic [7:0]        WAKE_SRC_INTERRUPT_CONTROL_REG,
  input wire logic [7:0]        WAKE_SRC_PERIPHERAL_IRQ_FLAGS_1,
  input wire logic [7:0]        INTERRUPT_CONTROL_REG_SET,
  input wire logic [7:0]        PERIPHERAL_IRQ_FLAGS_1_SET,
  input wire logic              PC_LOAD,
  input wire logic [12:0]       PC_VECTOR,
  input wire logic              BROWNOUT_FLAG,
  input wire logic              IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // ----------------------------------------
  // Wake-up side effects
  // ----------------------------------------
  property p_vec;
    PC_LOAD |-> PC_VECTOR == 13'h0004;
  endproperty
  a_vec: assert property (p_vec) else $error("vector wrong at load");
  property p_load_cause;
    PC_LOAD |-> $past(WAKE_IRQ & GLOBAL_IRQ_ENABLE);
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("load without enabled irq wake");
  property p_load_pulse;
    PC_LOAD |=> !PC_LOAD;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load longer than one cycle");
  property p_ic_set;
    |INTERRUPT_CONTROL_REG_SET |-> $past(WAKE_IRQ)
      && INTERRUPT_CONTROL_REG_SET == $past(WAKE_SRC_INTERRUPT_CONTROL_REG);
  endproperty
  a_ic_set: assert property (p_ic_set) else $error("control flag set mismatch");
  property p_pf_set;
    |PERIPHERAL_IRQ_FLAGS_1_SET |-> $past(WAKE_IRQ)
      && PERIPHERAL_IRQ_FLAGS_1_SET == $past(WAKE_SRC_PERIPHERAL_IRQ_FLAGS_1);
  endproperty
  a_pf_set: assert property (p_pf_set) else $error("peripheral flag set mismatch");

  // ----------------------------------------
  // Reset effects and read data
  // ----------------------------------------
  property p_bor_clear;
    BROWNOUT_RESET |-> ##[1:2] !BROWNOUT_FLAG;
  endproperty
  a_bor_clear: assert property (p_bor_clear) else $error("brown-out bit not cleared");
  property p_adc1_bits;
    RD && ADDR == 9'h09F |=> (RDATA & 8'h4F) == 8'h00;
  endproperty
  a_adc1_bits: assert property (p_adc1_bits) else $error("unimplemented adc bits set");
  property p_pe_bits;
    RD && ADDR == 9'h089 |=> RDATA[7:4] == 4'h0;
  endproperty
  a_pe_bits: assert property (p_pe_bits) else $error("unimplemented direction bits set");
  property p_idle_zero;
    !RD |=> RDATA == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data without read");

  c_load: cover property (PC_LOAD);
  c_full: cover property (BROWNOUT_RESET && SUPPLY_CRITICAL);
  c_irq: cover property (IRQ);
endmodule : rir_top_sva

// >>> verification/rir_top_bench.sv
`timescale 1ns/1ps
module rir_top_bench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [8:0]  addr = 9'h000;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [7:0]  rdata;
  logic [3:0]  mode = 4'h0;
  logic [3:0]  rst_src = 4'h0;
  logic        sleep_req = 1'b0;
  logic        wake_irq = 1'b0;
  logic        wdt_wake = 1'b0;
  logic        global_irq_enable = 1'b0;
  logic [7:0]  src_ic = 8'h00;
  logic [7:0]  src_pf = 8'h00;
  logic [7:0]  set_ic;
  logic [7:0]  set_pf;
  logic        pc_load;
  logic [12:0] pc_vector;
  logic        asleep;
  logic        bor_flag;
  logic        irq;
  int          fails = 0;
  int          n_tests = 0;
  logic [16:0] por_tab [8] = '{{9'h081, 8'hFF}, {9'h089, 8'h0F}, {9'h08F, 8'h60}, {9'h098, 8'h02},
                               {9'h09D, 8'h01}, {9'h105, 8'h08}, {9'h08E, 8'h10}, {9'h092, 8'hFF}};

  always #5 clk = ~clk;

  // Reset source order: pin, watchdog, brown-out, critical supply
  rir_top i_dut (
    .CLK                             (clk),
    .RESET                           (reset),
    .ADDR                            (addr),
    .WDATA                           (wdata),
    .WR                              (wr_s),
    .RD                              (rd_s),
    .RDATA                           (rdata),
    .SYNC_SERIAL_MODE_SELECT         (mode),
    .EXTERNAL_RESET_PIN              (rst_src[3]),
    .WATCHDOG_TIMER_RESET            (rst_src[2]),
    .BROWNOUT_RESET                  (rst_src[1]),
    .SUPPLY_CRITICAL                 (rst_src[0]),
    .SLEEP_REQ                       (sleep_req),
    .WAKE_IRQ                        (wake_irq),
    .WATCHDOG_TIMER_WAKE             (wdt_wake),
    .GLOBAL_IRQ_ENABLE               (global_irq_enable),
    .WAKE_SRC_INTERRUPT_CONTROL_REG  (src_ic),
    .WAKE_SRC_PERIPHERAL_IRQ_FLAGS_1 (src_pf),
    .INTERRUPT_CONTROL_REG_SET       (set_ic),
    .PERIPHERAL_IRQ_FLAGS_1_SET      (set_pf),
    .PC_LOAD                         (pc_load),
    .PC_VECTOR                       (pc_vector),
    .ASLEEP                          (asleep),
    .BROWNOUT_FLAG                   (bor_flag),
    .IRQ                             (irq)
  );

  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chkb(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : chkb

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [8:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask : rdc

  task automatic rst_pulse(input logic [3:0] s);
    @(posedge clk);
    rst_src <= s;
    @(posedge clk);
    rst_src <= 4'h0;
  endtask : rst_pulse

  task automatic set_mode(input logic [3:0] m);
    @(posedge clk);
    mode <= m;
  endtask : set_mode

  // Output may lag the cause by one or two edges
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk);
    #1;
    chkb("irq", v, irq);
  endtask : irq_is

  task automatic doze;
    int i;
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    for (i = 0; i < 8 && asleep !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (asleep !== 1'b1)
    begin
      fails++;
      stop_test();
    end
  endtask : doze

  task automatic wake(input logic by_irq, input logic en);
    @(posedge clk);
    wake_irq <= by_irq;
    wdt_wake <= !by_irq;
    global_irq_enable      <= en;
    src_ic   <= 8'h02;
    src_pf   <= 8'h40;
    @(posedge clk);
    wake_irq <= 1'b0;
    wdt_wake <= 1'b0;
    #1;
    chkb("pc_load", by_irq & en, pc_load);
    chkb("pc_vector", 1'b1, pc_vector === 13'h0004);
    chk("control_set", by_irq ? 8'h02 : 8'h00, set_ic);
    chk("periph_set", by_irq ? 8'h40 : 8'h00, set_pf);
    @(posedge clk);
    #1;
    chkb("pc_load_end", 1'b0, pc_load);
  endtask : wake

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 8; k++)
      rdc(por_tab[k][16:8], por_tab[k][7:0], "por_value");
    rdc(9'h1F0, 8'h01, "evt_stat");
    wr(9'h09F, 8'hFF);
    rdc(9'h09F, 8'hB0, "adc_ctrl1");
    wr(9'h089, 8'hFF);
    rdc(9'h089, 8'h0F, "pe_dir");
    wr(9'h107, 8'hFF);
    rdc(9'h107, 8'hFB, "cmp1");
    rdc(9'h000, 8'h00, "unmapped");
    wr(9'h085, 8'h12);
    wr(9'h01C, 8'h5A);
    wr(9'h08E, 8'h01);
    wr(9'h1F0, 8'hFF);
    rst_pulse(4'h8);
    rdc(9'h085, 8'hFF, "pa_dir");
    rdc(9'h01C, 8'h5A, "cc2_hi");
    rdc(9'h08E, 8'h01, "pwr_stat");
    chkb("bor_flag", 1'b1, bor_flag);
    rdc(9'h1F0, 8'h04, "evt_stat");
    rst_pulse(4'h4);
    rdc(9'h08E, 8'h01, "pwr_stat");
    rdc(9'h1F0, 8'h0C, "evt_stat");
    rst_pulse(4'h2);
    rdc(9'h08E, 8'h00, "pwr_stat");
    rdc(9'h01C, 8'h5A, "cc2_hi");
    chkb("bor_flag", 1'b0, bor_flag);
    wr(9'h08E, 8'h01);
    rst_pulse(4'h3);
    rdc(9'h01C, 8'h00, "cc2_hi");
    rdc(9'h08E, 8'h10, "pwr_stat");
    // Interrupt raise, mask and clear
    wr(9'h1F0, 8'hFF);
    wr(9'h1F1, 8'h04);
    irq_is(1'b0);
    rst_pulse(4'h8);
    irq_is(1'b1);
    wr(9'h1F1, 8'h00);
    irq_is(1'b0);
    wr(9'h1F1, 8'h04);
    irq_is(1'b1);
    wr(9'h1F0, 8'h04);
    irq_is(1'b0);
    set_mode(4'h9);
    wr(9'h093, 8'h3C);
    set_mode(4'h0);
    rdc(9'h093, 8'h00, "ss_addr");
    wr(9'h093, 8'h11);
    set_mode(4'h9);
    rdc(9'h093, 8'h3C, "ss_mask");
    // wake keeps contents except fixed ones
    wr(9'h092, 8'h20);
    wr(9'h086, 8'h33);
    doze();
    wake(1'b1, 1'b1);
    rdc(9'h092, 8'hFF, "t2_period");
    rdc(9'h086, 8'h33, "pb_dir");
    rdc(9'h093, 8'hFF, "ss_mask");
    set_mode(4'h0);
    rdc(9'h093, 8'h11, "ss_addr");
    doze();
    wake(1'b1, 1'b0);
    doze();
    wake(1'b0, 1'b1);
    rdc(9'h1F0, 8'h60, "evt_stat");
    stop_test();
  end
endmodule : rir_top_bench

bind rir_top rir_top_sva #(.ADDR_W(ADDR_W)) i_sva (
  .CLK                             (CLK),
  .RESET                           (RESET),
  .ADDR                            (ADDR),
  .RD                              (RD),
  .RDATA                           (RDATA),
  .BROWNOUT_RESET                  (BROWNOUT_RESET),
  .SUPPLY_CRITICAL                 (SUPPLY_CRITICAL),
  .WAKE_IRQ                        (WAKE_IRQ),
  .GLOBAL_IRQ_ENABLE               (GLOBAL_IRQ_ENABLE),
  .WAKE_SRC_INTERRUPT_CONTROL_REG  (WAKE_SRC_INTERRUPT_CONTROL_REG),
  .WAKE_SRC_PERIPHERAL_IRQ_FLAGS_1 (WAKE_SRC_PERIPHERAL_IRQ_FLAGS_1),
  .INTERRUPT_CONTROL_REG_SET       (INTERRUPT_CONTROL_REG_SET),
  .PERIPHERAL_IRQ_FLAGS_1_SET      (PERIPHERAL_IRQ_FLAGS_1_SET),
  .PC_LOAD                         (PC_LOAD),
  .PC_VECTOR                       (PC_VECTOR),
  .BROWNOUT_FLAG                   (BROWNOUT_FLAG),
  .IRQ                             (IRQ)
);
